// *** rtl/fpb_pkg.sv ***
// package for the fetch protection / burst buffer front end
// assumes one 20 MHz clock and an asynchronous active-high reset
package fpb_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned NUM_REGIONS = 4;
  localparam int unsigned BTC_ENTRIES = 8;
  localparam int unsigned BTC_SLOTS = 4;
  localparam int unsigned SLOT_W = 38;
  localparam int unsigned VRAM_WORDS = 1024;
  localparam logic [4:0] SIZE_MIN_LOG2 = 5'h0B;
  localparam logic [4:0] SIZE_MAX_LOG2 = 5'h1F;
  localparam logic [31:0] VEC_PROT = 32'h0000_1300;
  localparam logic [31:0] VEC_EXT_IRQ = 32'h0000_0500;
  localparam logic [31:0] VEC_SPACING = 32'h0000_0100;
  localparam logic [31:0] VEC_TABLE_MASK = 32'h0000_3F00;
  localparam logic [31:0] INT_MEM_BASE_RST = 32'h0000_0000;
  localparam logic [5:0] EXT_IRQ_CODES = 6'h30;
  localparam logic [11:0] EXT_VEC_BASE_OFS = 12'h000;
  localparam logic [1:0] VRAM_UBUS_CYC = 2'h1;
  localparam logic [1:0] VRAM_LS_CYC = 2'h3;
  localparam int unsigned STAT_GUARD_BIT = 3;
  localparam int unsigned STAT_PROT_BIT = 4;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] base;
    logic [4:0] size_log2;
    logic enable;
    logic super_only;
    logic guarded;
  } fpb_region_t;

  typedef struct packed {
    logic super_only;
    logic guarded;
  } fpb_global_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic supervisor;
    logic speculative;
    logic show_cycle;
    logic trace;
    logic debug;
    logic is_vector;
  } fpb_fetch_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic burst;
    logic show_cycle;
    logic trace;
    logic debug;
  } fpb_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] target;
    logic [BTC_SLOTS*SLOT_W-1:0] slots;
    logic [31:0] next_addr;
  } fpb_bte_t;

  typedef enum logic [1:0] {
    FPB_IDLE = 2'b00,
    FPB_ADDR = 2'b01,
    FPB_DATA = 2'b10
  } fpb_bus_state_t;

  typedef enum logic [1:0] {
    FPB_VR_IDLE = 2'b00,
    FPB_VR_WAIT = 2'b01,
    FPB_VR_DONE = 2'b10
  } fpb_vram_state_t;
endpackage

// *** rtl/fpb_top.sv ***
// fetch front end: region protector, vector relocation, bus interface,
// branch target cache and vocabulary RAM, all in one module
// assumes the core holds a fetch request until it is granted or faulted
`timescale 1ns/1ns
`default_nettype none
module fpb_top (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire fpb_pkg::fpb_fetch_t I_FETCH,
  output logic O_FETCH_GRANT,
  output logic O_PROT_EXC,
  output logic [31:0] O_PROT_VECTOR,
  output logic [31:0] O_PROT_STATUS,
  input wire logic I_TRANSLATE_EN,
  input wire logic I_DECOMP_ON,
  input wire fpb_pkg::fpb_region_t [3:0] I_REGION,
  input wire fpb_pkg::fpb_global_t I_GLOBAL,
  input wire logic I_RELOC_EN,
  input wire logic [31:0] I_INT_MEM_BASE,
  input wire logic I_EXT_IRQ_SPLIT_EN,
  input wire logic [5:0] I_EXT_IRQ_CODE,
  input wire logic I_BURST_EN,
  output fpb_pkg::fpb_bus_req_t O_BUS_REQ,
  output logic O_BUS_ABORT,
  input wire logic I_BUS_ACK,
  input wire logic I_BUS_BURST_OK,
  input wire logic I_BUS_LAST,
  input wire logic [31:0] I_BUS_RDATA,
  input wire logic [5:0] I_BUS_RBITS,
  output logic O_INSN_VALID,
  output logic [37:0] O_INSN,
  output logic O_INSN_FROM_CACHE,
  input wire logic I_COF,
  input wire logic I_BTC_EN,
  input wire logic I_BTC_INVALIDATE,
  input wire logic I_VR_REQ,
  input wire logic I_VR_FROM_LS,
  input wire logic I_VR_WRITE,
  input wire logic [1:0] I_VR_SIZE,
  input wire logic [11:0] I_VR_ADDR,
  input wire logic [31:0] I_VR_WDATA,
  output logic O_VR_DONE,
  output logic [31:0] O_VR_RDATA,
  output logic O_VR_BUSY
);
  typedef struct packed {
    fpb_pkg::fpb_bus_state_t bus_st;
    fpb_pkg::fpb_bus_req_t req;
    logic burst_live;
    logic [1:0] beat;
    logic [1:0] fill_slot;
    logic filling;
    logic [2:0] fifo_ptr;
    logic [2:0] hit_idx;
    logic [1:0] hit_slot;
    logic replay;
    logic exc;
    logic [31:0] vec;
    logic [31:0] status;
    logic insn_v;
    logic [37:0] insn;
    logic insn_c;
    fpb_pkg::fpb_vram_state_t vr_st;
    logic [1:0] vr_cnt;
    logic [31:0] vr_rdata;
    logic vr_done;
  } fpb_state_t;

  fpb_state_t s_q;
  fpb_state_t s_d;
  fpb_pkg::fpb_bte_t [fpb_pkg::BTC_ENTRIES-1:0] bte_q;
  fpb_pkg::fpb_bte_t [fpb_pkg::BTC_ENTRIES-1:0] bte_d;
  logic [31:0] vram_q [0:fpb_pkg::VRAM_WORDS-1];

  logic [3:0] match;
  logic [3:0] region_viol;
  logic [3:0] region_guard;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_region
      logic [31:0] mask;
      logic [4:0] sz;
      // sizes below the smallest are clamped so a region never shrinks under 2K
      assign sz = (I_REGION[g].size_log2 < fpb_pkg::SIZE_MIN_LOG2) ?
                  fpb_pkg::SIZE_MIN_LOG2 : I_REGION[g].size_log2;
      // a region spans 2^sz bytes from its base; the top code stands for the
      // whole 4G space, so the 2G size has no code of its own
      assign mask = (sz == fpb_pkg::SIZE_MAX_LOG2) ? 32'h0000_0000 :
                    (32'hFFFF_FFFF << sz);
      assign match[g] = I_REGION[g].enable &&
                        ((I_FETCH.addr & mask) == (I_REGION[g].base & mask));
      assign region_viol[g] = I_REGION[g].super_only && !I_FETCH.supervisor;
      assign region_guard[g] = I_REGION[g].guarded && I_FETCH.speculative;
    end
  endgenerate

  logic [7:0] hit_vec;
  generate
    for (g = 0; g < fpb_pkg::BTC_ENTRIES; g++) begin : g_hit
      assign hit_vec[g] = I_BTC_EN && bte_q[g].valid && bte_q[g].target == I_FETCH.addr;
    end
  endgenerate

  logic [5:0] irq_code;
  // codes beyond the last vector fold onto the last one
  assign irq_code = (I_EXT_IRQ_CODE < fpb_pkg::EXT_IRQ_CODES) ? I_EXT_IRQ_CODE :
                    (fpb_pkg::EXT_IRQ_CODES - 6'h01);

  logic eff_viol;
  logic eff_guard;
  logic fault;
  logic [31:0] xlat_addr;
  logic [2:0] hit_sel;
  logic hit_any;

  always_comb begin
    // lowest-numbered match takes priority, global entry last
    eff_viol = I_GLOBAL.super_only && !I_FETCH.supervisor;
    eff_guard = I_GLOBAL.guarded && I_FETCH.speculative;
    for (int i = 3; i >= 0; i--) begin
      if (match[i]) begin
        eff_viol = region_viol[i];
        eff_guard = region_guard[i];
      end
    end
    fault = I_TRANSLATE_EN && I_FETCH.valid && (eff_viol || eff_guard);
    hit_any = 1'b0;
    hit_sel = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_any = 1'b1;
        hit_sel = 3'(i);
      end
    end
    xlat_addr = I_FETCH.addr;
    if (I_FETCH.is_vector && I_RELOC_EN) begin
      xlat_addr = I_INT_MEM_BASE | (I_FETCH.addr & fpb_pkg::VEC_TABLE_MASK);
      if (I_EXT_IRQ_SPLIT_EN &&
          (I_FETCH.addr & fpb_pkg::VEC_TABLE_MASK) == fpb_pkg::VEC_EXT_IRQ) begin
        // split vectors sit just past the relocated table, one spacing apart
        xlat_addr = I_INT_MEM_BASE + fpb_pkg::VEC_TABLE_MASK + fpb_pkg::VEC_SPACING +
                    {18'h0, irq_code, 8'h00};
      end
    end
  end

  logic [31:0] exc_status;
  always_comb begin
    exc_status = 32'h0000_0000;
    // exactly one cause is reported; a guard hit outranks a permission miss
    if (eff_guard) begin
      exc_status[fpb_pkg::STAT_GUARD_BIT] = 1'b1;
    end else begin
      exc_status[fpb_pkg::STAT_PROT_BIT] = 1'b1;
    end
  end

  logic fetch_take;
  assign fetch_take = I_FETCH.valid && s_q.bus_st == fpb_pkg::FPB_IDLE && !s_q.replay;
  // a refused fetch still goes out when it is a show cycle, for tracking
  assign O_FETCH_GRANT = fetch_take && (!fault || I_FETCH.show_cycle);
  assign O_BUS_ABORT = fetch_take && fault && !I_FETCH.show_cycle;
  assign O_BUS_REQ = s_q.req;
  assign O_PROT_EXC = s_q.exc;
  assign O_PROT_VECTOR = s_q.vec;
  assign O_PROT_STATUS = s_q.status;
  assign O_INSN_VALID = s_q.insn_v;
  assign O_INSN = s_q.insn;
  assign O_INSN_FROM_CACHE = s_q.insn_c;
  assign O_VR_DONE = s_q.vr_done;
  assign O_VR_RDATA = s_q.vr_rdata;
  assign O_VR_BUSY = s_q.vr_st != fpb_pkg::FPB_VR_IDLE;

  logic [9:0] vr_word;
  logic [31:0] vr_wmask;
  assign vr_word = I_VR_ADDR[11:2];

  logic [31:0] vr_rd_word;
  logic [7:0] vr_rd_byte;
  logic [15:0] vr_rd_half;
  // lanes are picked by the low address bits, lowest byte at offset zero
  always_comb begin
    vr_rd_word = vram_q[vr_word];
    vr_rd_byte = vr_rd_word[{I_VR_ADDR[1:0], 3'h0} +: 8];
    vr_rd_half = vr_rd_word[{I_VR_ADDR[1], 4'h0} +: 16];
  end

  always_comb begin
    s_d = s_q;
    bte_d = bte_q;
    s_d.exc = 1'b0;
    s_d.insn_v = 1'b0;
    s_d.insn_c = 1'b0;
    s_d.vr_done = 1'b0;
    vr_wmask = 32'h0000_0000;
    case (s_q.bus_st)
      fpb_pkg::FPB_IDLE: begin
        // request leaves the cycle after it is taken; until then the bus stays parked
        s_d.req.valid = 1'b0;
        if (s_q.replay) begin
          s_d.insn_v = 1'b1;
          s_d.insn_c = 1'b1;
          s_d.insn = bte_q[s_q.hit_idx].slots[s_q.hit_slot*38 +: 38];
          s_d.hit_slot = s_q.hit_slot + 2'h1;
          if (s_q.hit_slot == 2'h3) begin
            s_d.replay = 1'b0;
          end
        end else if (fetch_take) begin
          if (fault) begin
            s_d.exc = 1'b1;
            s_d.vec = fpb_pkg::VEC_PROT;
            s_d.status = exc_status;
          end
          if (I_COF && hit_any && !fault) begin
            s_d.replay = 1'b1;
            s_d.hit_idx = hit_sel;
            s_d.hit_slot = 2'h0;
          end else if (!fault || I_FETCH.show_cycle) begin
            s_d.req.valid = 1'b1;
            s_d.req.addr = xlat_addr;
            s_d.req.burst = I_BURST_EN && !I_DECOMP_ON && !I_FETCH.debug;
            s_d.req.show_cycle = I_FETCH.show_cycle;
            s_d.req.trace = I_FETCH.trace;
            s_d.req.debug = I_FETCH.debug;
            s_d.bus_st = fpb_pkg::FPB_ADDR;
            s_d.beat = 2'h0;
            s_d.filling = I_COF && I_BTC_EN && !fault;
            s_d.fill_slot = 2'h0;
            if (s_d.filling) begin
              bte_d[s_q.fifo_ptr].valid = 1'b0;
              bte_d[s_q.fifo_ptr].target = I_FETCH.addr;
            end
          end
        end
      end
      fpb_pkg::FPB_ADDR: begin
        if (I_BUS_ACK) begin
          s_d.req.valid = 1'b0;
          s_d.burst_live = s_q.req.burst && I_BUS_BURST_OK;
          s_d.bus_st = fpb_pkg::FPB_DATA;
        end
      end
      fpb_pkg::FPB_DATA: begin
        if (I_BUS_ACK) begin
          s_d.insn_v = 1'b1;
          s_d.insn = {I_BUS_RBITS, I_BUS_RDATA};
          s_d.beat = s_q.beat + 2'h1;
          if (s_q.filling) begin
            bte_d[s_q.fifo_ptr].slots[s_q.fill_slot*38 +: 38] = {I_BUS_RBITS, I_BUS_RDATA};
            bte_d[s_q.fifo_ptr].next_addr = s_q.req.addr + {28'h0, s_q.beat, 2'h0} + 32'h4;
            s_d.fill_slot = s_q.fill_slot + 2'h1;
          end
          if (I_BUS_LAST || !s_q.burst_live || s_q.beat == 2'h3) begin
            s_d.bus_st = fpb_pkg::FPB_IDLE;
            if (s_q.filling) begin
              bte_d[s_q.fifo_ptr].valid = 1'b1;
              s_d.fifo_ptr = s_q.fifo_ptr + 3'h1;
              s_d.filling = 1'b0;
            end
          end
        end
      end
      default: s_d.bus_st = fpb_pkg::FPB_IDLE;
    endcase
    if (I_BTC_INVALIDATE || !I_BTC_EN) begin
      for (int i = 0; i < fpb_pkg::BTC_ENTRIES; i++) begin
        bte_d[i].valid = 1'b0;
      end
      s_d.replay = 1'b0;
      s_d.filling = 1'b0;
    end
    case (s_q.vr_st)
      fpb_pkg::FPB_VR_IDLE: begin
        if (I_VR_REQ && !I_DECOMP_ON) begin
          s_d.vr_cnt = I_VR_FROM_LS ? fpb_pkg::VRAM_LS_CYC : fpb_pkg::VRAM_UBUS_CYC;
          s_d.vr_st = fpb_pkg::FPB_VR_WAIT;
        end
      end
      fpb_pkg::FPB_VR_WAIT: begin
        s_d.vr_cnt = s_q.vr_cnt - 2'h1;
        if (s_q.vr_cnt == 2'h1) begin
          s_d.vr_st = fpb_pkg::FPB_VR_DONE;
        end
      end
      fpb_pkg::FPB_VR_DONE: begin
        s_d.vr_done = 1'b1;
        s_d.vr_st = fpb_pkg::FPB_VR_IDLE;
        case (I_VR_SIZE)
          2'h0: s_d.vr_rdata = {24'h0, vr_rd_byte};
          2'h1: s_d.vr_rdata = {16'h0, vr_rd_half};
          default: s_d.vr_rdata = vr_rd_word;
        endcase
        case (I_VR_SIZE)
          2'h0: vr_wmask = 32'h0000_00FF << {I_VR_ADDR[1:0], 3'h0};
          2'h1: vr_wmask = 32'h0000_FFFF << {I_VR_ADDR[1], 4'h0};
          default: vr_wmask = 32'hFFFF_FFFF;
        endcase
        if (!I_VR_WRITE) begin
          vr_wmask = 32'h0000_0000;
        end
      end
      default: s_d.vr_st = fpb_pkg::FPB_VR_IDLE;
    endcase
  end

  logic [31:0] vr_wshift;
  always_comb begin
    case (I_VR_SIZE)
      2'h0: vr_wshift = {4{I_VR_WDATA[7:0]}};
      2'h1: vr_wshift = {2{I_VR_WDATA[15:0]}};
      default: vr_wshift = I_VR_WDATA;
    endcase
  end

  // memory has no reset; contents are undefined until written
  always_ff @(posedge I_CLK) begin
    if (vr_wmask != 32'h0000_0000) begin
      vram_q[vr_word] <= (vram_q[vr_word] & ~vr_wmask) | (vr_wshift & vr_wmask);
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_q <= '0;
      bte_q <= '0;
    end else begin
      s_q <= s_d;
      bte_q <= bte_d;
    end
  end
endmodule
`default_nettype wire

// *** testbench/fpb_properties.sv ***
// port-level checker for the fetch front end
// assumes it is bound onto fpb_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module fpb_properties (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire fpb_pkg::fpb_fetch_t I_FETCH,
  input wire logic O_FETCH_GRANT,
  input wire logic O_BUS_ABORT,
  input wire logic O_PROT_EXC,
  input wire logic [31:0] O_PROT_VECTOR,
  input wire logic [31:0] O_PROT_STATUS,
  input wire logic I_TRANSLATE_EN,
  input wire logic I_DECOMP_ON,
  input wire logic I_BURST_EN,
  input wire fpb_pkg::fpb_bus_req_t O_BUS_REQ,
  input wire logic I_BUS_ACK,
  input wire logic I_VR_REQ,
  input wire logic I_VR_FROM_LS,
  input wire logic O_VR_BUSY,
  input wire logic O_VR_DONE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_vr_go; I_VR_REQ && !O_VR_BUSY && !I_DECOMP_ON; endsequence
  sequence s_ubus_done; !O_VR_DONE [*2] ##1 O_VR_DONE; endsequence
  sequence s_ls_done; !O_VR_DONE [*4] ##1 O_VR_DONE; endsequence
  a_grant_abort_excl: assert property (!(O_FETCH_GRANT && O_BUS_ABORT))
    else $error("grant and abort together");
  a_abort_raises_exc: assert property (O_BUS_ABORT |=> O_PROT_EXC && O_PROT_VECTOR == fpb_pkg::VEC_PROT)
    else $error("refused fetch without exception vector");
  a_exc_has_cause: assert property (O_PROT_EXC |-> $past(O_BUS_ABORT))
    else $error("exception without refused fetch");
  a_status_one_bit: assert property (O_PROT_EXC |-> O_PROT_STATUS[3] != O_PROT_STATUS[4])
    else $error("status bits not exactly one");
  a_off_no_refuse: assert property (!I_TRANSLATE_EN |-> !O_BUS_ABORT)
    else $error("fetch refused with checking off");
  a_req_from_grant: assert property ($rose(O_BUS_REQ.valid) |-> $past(O_FETCH_GRANT))
    else $error("bus request without grant");
  a_attr_forward: assert property ($rose(O_BUS_REQ.valid) |->
    O_BUS_REQ.trace == $past(I_FETCH.trace) && O_BUS_REQ.debug == $past(I_FETCH.debug))
    else $error("fetch attributes not forwarded");
  a_req_stands: assert property (O_BUS_REQ.valid && !I_BUS_ACK |=>
    O_BUS_REQ.valid && $stable(O_BUS_REQ.addr))
    else $error("bus request dropped before ack");
  a_burst_needs_en: assert property (O_BUS_REQ.valid && O_BUS_REQ.burst |-> I_BURST_EN && !I_DECOMP_ON)
    else $error("burst requested while disabled");
  a_vr_ubus_time: assert property (s_vr_go ##0 !I_VR_FROM_LS |=> s_ubus_done)
    else $error("bus side ram access not two clocks");
  a_vr_ls_time: assert property (s_vr_go ##0 I_VR_FROM_LS |=> s_ls_done)
    else $error("load store ram access not four clocks");
  a_vr_refused: assert property (I_VR_REQ && I_DECOMP_ON && !O_VR_BUSY |=> !O_VR_DONE [*3])
    else $error("ram answered while decompression on");
endmodule
bind fpb_top fpb_properties u_chk (.*);
`default_nettype wire

// *** testbench/fpb_bus_model.sv ***
// unified bus slave model facing the fetch bus interface
// assumes one clock; the address phase is answered after i_wait cycles
`timescale 1ns/1ns
`default_nettype none
module fpb_bus_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire fpb_pkg::fpb_bus_req_t i_req,
  input wire logic i_burst_allow,
  input wire logic [1:0] i_wait,
  output logic o_ack,
  output logic o_burst_ok,
  output logic o_last,
  output logic [31:0] o_rdata,
  output logic [5:0] o_rbits,
  output logic [7:0] o_n_req
);
  logic busy, first;
  logic [1:0] cnt, beat, nb;
  logic [31:0] addr, d;
  assign nb = first ? 2'h0 : beat + 2'h1;
  assign d = addr + {28'h0, nb, 2'h0};
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {busy, first, cnt, beat, o_ack, o_burst_ok, o_last} <= '0;
      {o_rdata, o_rbits, addr, o_n_req} <= '0;
    end else if (!busy) begin
      // released data lines must not keep looking valid
      o_rdata <= ~o_rdata;
      o_rbits <= ~o_rbits;
      cnt <= i_req.valid ? cnt + 2'h1 : 2'h0;
      if (i_req.valid && cnt == i_wait) begin
        o_ack <= 1'b1;
        o_burst_ok <= i_req.burst & i_burst_allow;
        addr <= i_req.addr;
        o_n_req <= o_n_req + 8'h1;
        busy <= 1'b1;
        first <= 1'b1;
        cnt <= 2'h0;
      end
    end else if (o_last) begin
      o_ack <= 1'b0;
      o_last <= 1'b0;
      o_rdata <= ~o_rdata;
      busy <= 1'b0;
    end else begin
      first <= 1'b0;
      beat <= nb;
      o_rdata <= d;
      o_rbits <= ~d[5:0];
      o_last <= !o_burst_ok || nb == 2'h3;
    end
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the fetch front end
// assumes the bus model answers fetches; a cycle ceiling cuts hangs
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic I_CLK, I_RST, O_FETCH_GRANT, O_PROT_EXC, O_BUS_ABORT, O_INSN_VALID;
  logic O_INSN_FROM_CACHE, I_TRANSLATE_EN, I_DECOMP_ON, I_RELOC_EN, I_EXT_IRQ_SPLIT_EN;
  logic I_BURST_EN, I_COF, I_BTC_EN, I_BTC_INVALIDATE, I_VR_REQ, I_VR_FROM_LS, I_VR_WRITE;
  logic O_VR_DONE, O_VR_BUSY, I_BUS_ACK, I_BUS_BURST_OK, I_BUS_LAST, allow, vec;
  logic [31:0] O_PROT_VECTOR, O_PROT_STATUS, I_INT_MEM_BASE, I_BUS_RDATA, I_VR_WDATA;
  logic [31:0] O_VR_RDATA, rd;
  logic [5:0] I_EXT_IRQ_CODE, I_BUS_RBITS;
  logic [1:0] I_VR_SIZE, wait_n;
  logic [11:0] I_VR_ADDR;
  logic [37:0] O_INSN;
  logic [7:0] n_req;
  fpb_pkg::fpb_fetch_t I_FETCH;
  fpb_pkg::fpb_region_t [3:0] I_REGION;
  fpb_pkg::fpb_global_t I_GLOBAL;
  fpb_pkg::fpb_bus_req_t O_BUS_REQ;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  localparam logic [31:0] A = 32'h0000_8000;
  fpb_top u_dut (.*);
  fpb_bus_model u_bus (.i_clk(I_CLK), .i_rst(I_RST), .i_req(O_BUS_REQ), .i_burst_allow(allow),
    .i_wait(wait_n), .o_ack(I_BUS_ACK), .o_burst_ok(I_BUS_BURST_OK), .o_last(I_BUS_LAST),
    .o_rdata(I_BUS_RDATA), .o_rbits(I_BUS_RBITS), .o_n_req(n_req));
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // st: 0 granted, 1 guard fault, 2 protection fault
  task automatic fetch(input logic [31:0] a, input logic [31:0] ea,
                       input int sup, input int spec, input int st, input int beats, input int hit);
    int n, k;
    logic [7:0] r0;
    logic [31:0] d;
    r0 = n_req;
    @(posedge I_CLK);
    I_FETCH <= '{1'b1, a, sup[0], spec[0], 1'b0, 1'b1, spec[0], vec};
    n = 0;
    do begin
      @(negedge I_CLK);
      n++;
    end while (O_FETCH_GRANT !== 1'b1 && O_BUS_ABORT !== 1'b1 && n < 40);
    chk(38'(O_BUS_ABORT), 38'(st != 0));
    @(posedge I_CLK);
    I_FETCH.valid <= 1'b0;
    @(negedge I_CLK);
    if (st != 0) begin
      chk(38'(O_PROT_EXC), 38'h1);
      chk(38'(O_PROT_STATUS[4:3]), 38'(st));
      chk(38'(O_PROT_VECTOR), 38'(fpb_pkg::VEC_PROT));
    end
    k = 0;
    for (n = 0; n < 16; n++) begin
      if (O_INSN_VALID === 1'b1) begin
        d = ea + 32'(k * 4);
        chk(O_INSN, {~d[5:0], d});
        chk(38'(O_INSN_FROM_CACHE), 38'(hit));
        k++;
      end
      @(negedge I_CLK);
    end
    chk(38'(k), 38'(beats));
    chk(38'(n_req - r0), 38'(hit == 0 && st == 0));
  endtask
  task automatic vr(input int wr, input int ls, input int sz,
                    input logic [11:0] ad, input logic [31:0] wd, input int lat);
    int n;
    @(posedge I_CLK);
    I_VR_REQ <= 1'b1;
    I_VR_WRITE <= wr[0];
    I_VR_FROM_LS <= ls[0];
    I_VR_SIZE <= sz[1:0];
    I_VR_ADDR <= ad;
    I_VR_WDATA <= wd;
    @(posedge I_CLK);
    I_VR_REQ <= 1'b0;
    n = 0;
    @(negedge I_CLK);
    while (O_VR_DONE !== 1'b1 && n < 8) begin
      @(negedge I_CLK);
      n++;
    end
    chk(38'(n), 38'(lat));
    rd = O_VR_RDATA;
  endtask
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    I_RST = 1'b1;
    I_FETCH = '0;
    I_REGION = '0;
    I_GLOBAL = '0;
    {I_TRANSLATE_EN, I_DECOMP_ON, I_RELOC_EN, I_EXT_IRQ_SPLIT_EN, I_BURST_EN} = '0;
    {I_COF, I_BTC_EN, I_BTC_INVALIDATE, I_VR_REQ, I_VR_FROM_LS, I_VR_WRITE, allow, vec} = '0;
    {I_EXT_IRQ_CODE, I_VR_SIZE, wait_n, I_VR_ADDR, I_VR_WDATA} = '0;
    I_INT_MEM_BASE = 32'h0040_0000;
    repeat (4) @(posedge I_CLK);
    I_RST <= 1'b0;
    I_TRANSLATE_EN <= 1'b1;
    I_GLOBAL <= '{1'b1, 1'b0};
    I_REGION[0] <= '{32'h0001_0000, 5'h0B, 1'b1, 1'b1, 1'b0};
    I_REGION[1] <= '{32'h0001_0000, 5'h0F, 1'b1, 1'b0, 1'b1};
    I_REGION[2] <= '{32'h0010_0000, 5'h1F, 1'b0, 1'b1, 1'b1};
    I_REGION[3] <= '{32'h0020_0000, 5'h0B, 1'b1, 1'b0, 1'b0};
    fetch(32'h0001_0100, 32'h0001_0100, 1, 0, 0, 1, 0);
    fetch(32'h0001_0100, 32'h0001_0100, 0, 0, 2, 0, 0);
    fetch(32'h0001_0800, 32'h0001_0800, 0, 0, 0, 1, 0);
    fetch(32'h0001_4000, 32'h0001_4000, 1, 1, 1, 0, 0);
    fetch(32'h0020_0000, 32'h0020_0000, 0, 0, 0, 1, 0);
    fetch(32'h0030_0000, 32'h0030_0000, 0, 0, 2, 0, 0);
    fetch(32'h0030_0000, 32'h0030_0000, 1, 0, 0, 1, 0);
    I_REGION[0].enable <= 1'b0;
    fetch(32'h0001_0100, 32'h0001_0100, 1, 1, 1, 0, 0);
    I_TRANSLATE_EN <= 1'b0;
    fetch(32'h0001_4000, 32'h0001_4000, 0, 1, 0, 1, 0);
    for (int i = 0; i < 4; i++) begin
      I_BURST_EN <= i != 2;
      allow <= i != 1;
      I_DECOMP_ON <= i == 3;
      wait_n <= 2'(i);
      fetch(32'h2000 + 32'(i * 16), 32'h2000 + 32'(i * 16), 1, 0, 0, i == 0 ? 4 : 1, 0);
    end
    {I_DECOMP_ON, I_BURST_EN} <= 2'h0;
    vec <= 1'b1;
    I_RELOC_EN <= 1'b1;
    fetch(32'h0000_0700, 32'h0040_0700, 1, 0, 0, 1, 0);
    I_EXT_IRQ_SPLIT_EN <= 1'b1;
    I_EXT_IRQ_CODE <= 6'h05;
    fetch(32'h0000_0500, 32'h0040_4500, 1, 0, 0, 1, 0);
    I_EXT_IRQ_CODE <= 6'h32;
    fetch(32'h0000_0500, 32'h0040_6F00, 1, 0, 0, 1, 0);
    {vec, I_RELOC_EN} <= 2'h0;
    {I_BURST_EN, I_BTC_EN, I_COF} <= 3'h7;
    fetch(A, A, 1, 0, 0, 4, 0);
    fetch(A, A, 1, 0, 0, 4, 1);
    for (int k = 1; k < 8; k++) fetch(A + 32'(k * 64), A + 32'(k * 64), 1, 0, 0, 4, 0);
    fetch(A, A, 1, 0, 0, 4, 1);
    fetch(A + 32'h200, A + 32'h200, 1, 0, 0, 4, 0);
    fetch(A, A, 1, 0, 0, 4, 0);
    I_BTC_INVALIDATE <= 1'b1;
    @(posedge I_CLK);
    I_BTC_INVALIDATE <= 1'b0;
    fetch(A, A, 1, 0, 0, 4, 0);
    vr(1, 0, 2, 12'h010, 32'h1122_3344, 2);
    vr(0, 1, 2, 12'h010, 32'h0, 4);
    chk(38'(rd), 38'(32'h1122_3344));
    vr(1, 1, 1, 12'h012, 32'hBEEF_BEEF, 4);
    vr(0, 0, 2, 12'h010, 32'h0, 2);
    chk(38'(rd), 38'(32'hBEEF_3344));
    vr(1, 0, 0, 12'h013, 32'hAAAA_AAAA, 2);
    vr(0, 0, 2, 12'h010, 32'h0, 2);
    chk(38'(rd), 38'(32'hAAEF_3344));
    vr(0, 0, 0, 12'h013, 32'h0, 2);
    chk(38'(rd), 38'(32'h0000_00AA));
    I_DECOMP_ON <= 1'b1;
    vr(0, 0, 2, 12'h010, 32'h0, 8);
    end_sim();
  end
endmodule
`default_nettype wire
